// ---- housekeeping_adc_control.sv ----
// register file and sequencing for the temperature, battery and supply converters
//
// The plain strobed port was decided locally.
`timescale 1ns/1ps
// Function
// - temperature delta field bits 5-3: off, below 1, 1 LSB, 2 LSB, every
// - supply delta field bits 2-0: off, below 1, larger step, every; 7-6 zero
// - writing one to start bit 7 clears the pll fault flag
// - start bit 2 requests a supply conversion, self-clears on converter accept
// - start bit 1 requests a temperature conversion, self-clears on accept
// - start bit 0 requests a battery conversion, self-clears on accept
// - battery result below threshold raises an interrupt
// - supply result loads only when its interrupt is raised
// - battery result loads only when its interrupt is raised
// - temperature result loads only when its interrupt is raised
// - temperature converts on software request or periodically, 8-bit result
// - 2-bit period fields pick background interval; 00 disables it
// - background temperature interrupts only if change exceeds delta setting
module housekeeping_adc_control
  import housekeeping_pkg::*;
#(
  parameter int unsigned MINUTE_CYCLES = MINUTE_CYCLES_DEF
) (
  input  wire logic              sys_clk_in,
  input  wire logic              rst_in,
  input  wire reg_bus_t          bus_in,
  output logic [7:0]             rdata_out,
  input  wire conv_in_t          conv_in,
  output logic [NUM_CH-1:0]      conv_req_out,
  input  wire logic              pll_fault_set_in,
  output logic                   pll_fault_flag_out,
  output logic                   irq_out
);

  localparam logic [30:0] MINUTE_LAST = 31'(MINUTE_CYCLES - 1);

  logic [7:0]        temperature_result_r;
  logic [7:0]        battery_result_r;
  logic [7:0]        supply_result_r;
  logic [7:0]        change_delta_config_r;
  logic [7:0]        background_period_config_r;
  logic [7:0]        battery_low_threshold_r;
  logic [NUM_CH-1:0] start_r;
  logic [NUM_CH-1:0] pending_r;
  logic [NUM_CH-1:0] single_r;
  logic [NUM_CH-1:0] irq_status_r;
  logic [NUM_CH-1:0] irq_mask_r;
  logic              pll_fault_flag_r;
  logic [30:0]       minute_cnt_r;
  logic              minute_tick_r;
  logic [NUM_CH-1:0] bg_strobe;
  logic [NUM_CH-1:0] ack_take;
  logic [NUM_CH-1:0] done_take;
  logic [NUM_CH-1:0] irq_event;
  logic [NUM_CH-1:0][1:0] period_code;
  logic              temp_delta_hit;
  logic              supply_delta_hit;
  logic [7:0]        temp_change_delta;
  logic [7:0]        supply_diff;

  function automatic logic wr_at(input logic [7:0] addr);
    wr_at = bus_in.wr && bus_in.addr == addr;
  endfunction

  // one-minute enable for the interval timers
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      minute_cnt_r  <= 31'h0;
      minute_tick_r <= 1'b0;
    end else if (minute_cnt_r == MINUTE_LAST) begin
      minute_cnt_r  <= 31'h0;
      minute_tick_r <= 1'b1;
    end else begin
      minute_cnt_r  <= minute_cnt_r + 31'h1;
      minute_tick_r <= 1'b0;
    end
  end

  assign period_code[CH_BATT]   = background_period_config_r[BATT_BG_INTERVAL_LSB +: 2];
  assign period_code[CH_TEMP]   = background_period_config_r[TEMP_PERIOD_LSB +: 2];
  assign period_code[CH_SUPPLY] = background_period_config_r[SUPPLY_PERIOD_LSB +: 2];

  // per-channel request sequencer: idle, request held until accepted, converting
  for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_ch
    conv_state_t state_r;

    bg_interval_timer #(
      .MIN_01 (ch == CH_BATT ? MIN_16 : MIN_8),
      .MIN_10 (ch == CH_BATT ? MIN_4 : MIN_2),
      .MIN_11 (MIN_1)
    ) u_timer (
      .sys_clk_in     (sys_clk_in),
      .rst_in         (rst_in),
      .minute_tick_in (minute_tick_r),
      .period_code_in (period_code[ch]),
      .strobe_out     (bg_strobe[ch])
    );

    always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
        state_r      <= ST_IDLE;
        single_r[ch] <= 1'b0;
      end else begin
        case (state_r)
          ST_IDLE: begin
            if (start_r[ch] || pending_r[ch]) begin
              state_r      <= ST_REQ;
              single_r[ch] <= start_r[ch];
            end
          end
          ST_REQ: begin
            if (conv_in.ack[ch]) begin
              state_r <= ST_BUSY;
            end
          end
          ST_BUSY: begin
            if (conv_in.done[ch]) begin
              state_r <= ST_IDLE;
            end
          end
          default: state_r <= ST_IDLE;
        endcase
      end
    end

    assign ack_take[ch]     = state_r == ST_REQ && conv_in.ack[ch];
    assign done_take[ch]    = state_r == ST_BUSY && conv_in.done[ch];
    assign conv_req_out[ch] = state_r == ST_REQ;

    // a background tick landing on the accepting cycle is kept, not lost
    always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
        pending_r[ch] <= 1'b0;
      end else if (bg_strobe[ch]) begin
        pending_r[ch] <= 1'b1;
      end else if (ack_take[ch] && !single_r[ch]) begin
        pending_r[ch] <= 1'b0;
      end
    end
  end

  // start bits: software sets, acceptance clears, a fresh write wins
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      start_r <= '0;
    end else begin
      start_r <= (start_r & ~(ack_take & single_r))
               | (wr_at(CONV_START_ADDR) ? bus_in.wdata[NUM_CH-1:0] : '0);
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      pll_fault_flag_r <= 1'b0;
    end else if (pll_fault_set_in) begin
      pll_fault_flag_r <= 1'b1;
    end else if (wr_at(CONV_START_ADDR) && bus_in.wdata[PLL_ACK_BIT]) begin
      pll_fault_flag_r <= 1'b0;
    end
  end

  assign temp_change_delta   = abs_diff(conv_in.data[CH_TEMP], temperature_result_r);
  assign supply_diff = abs_diff(conv_in.data[CH_SUPPLY], supply_result_r);

  // compare against the held result, which is the last value that interrupted
  always_comb begin
    case (change_delta_config_r[TEMP_DELTA_LSB +: 3])
      TD_BELOW_1: temp_delta_hit = temp_change_delta > STEP_ZERO;
      TD_ONE:     temp_delta_hit = temp_change_delta > STEP_ONE;
      TD_TWO:     temp_delta_hit = temp_change_delta > STEP_TWO;
      TD_EVERY:   temp_delta_hit = 1'b1;
      default:    temp_delta_hit = 1'b0;
    endcase
  end

  always_comb begin
    case (change_delta_config_r[SUPPLY_DELTA_LSB +: 3])
      SD_BELOW_1: supply_delta_hit = supply_diff > STEP_ZERO;
      SD_STEP:    supply_delta_hit = supply_diff > SUPPLY_LARGE_STEP;
      SD_EVERY:   supply_delta_hit = 1'b1;
      default:    supply_delta_hit = 1'b0;
    endcase
  end

  assign irq_event[CH_TEMP]   = done_take[CH_TEMP] && (single_r[CH_TEMP] || temp_delta_hit);
  assign irq_event[CH_SUPPLY] = done_take[CH_SUPPLY]
                             && (single_r[CH_SUPPLY] || supply_delta_hit);
  assign irq_event[CH_BATT]   = done_take[CH_BATT]
                             && (single_r[CH_BATT]
                                 || conv_in.data[CH_BATT] < battery_low_threshold_r);

  // results: the converter load beats a same-cycle software write
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      temperature_result_r <= REG_RESET;
    end else if (irq_event[CH_TEMP]) begin
      temperature_result_r <= conv_in.data[CH_TEMP];
    end else if (wr_at(TEMP_RESULT_ADDR)) begin
      temperature_result_r <= bus_in.wdata;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      battery_result_r <= REG_RESET;
    end else if (irq_event[CH_BATT]) begin
      battery_result_r <= conv_in.data[CH_BATT];
    end else if (wr_at(BATT_RESULT_ADDR)) begin
      battery_result_r <= bus_in.wdata;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      supply_result_r <= REG_RESET;
    end else if (irq_event[CH_SUPPLY]) begin
      supply_result_r <= conv_in.data[CH_SUPPLY];
    end else if (wr_at(SUPPLY_RESULT_ADDR)) begin
      supply_result_r <= bus_in.wdata;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      change_delta_config_r      <= REG_RESET;
      background_period_config_r <= REG_RESET;
      battery_low_threshold_r    <= REG_RESET;
      irq_mask_r                 <= '0;
    end else begin
      if (wr_at(CHANGE_DELTA_ADDR)) begin
        change_delta_config_r <= {2'h0, bus_in.wdata[DELTA_USED_BITS-1:0]};
      end
      if (wr_at(BG_PERIOD_ADDR)) begin
        background_period_config_r <= {2'h0, bus_in.wdata[5:0]};
      end
      if (wr_at(BATT_THRESH_ADDR)) begin
        battery_low_threshold_r <= bus_in.wdata;
      end
      if (wr_at(IRQ_MASK_ADDR)) begin
        irq_mask_r <= bus_in.wdata[NUM_CH-1:0];
      end
    end
  end

  // write-one-to-clear, a new event in the same cycle stays set
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      irq_status_r <= '0;
    end else begin
      irq_status_r <= (irq_status_r
                       & ~(wr_at(IRQ_STATUS_ADDR) ? bus_in.wdata[NUM_CH-1:0] : '0))
                    | irq_event;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      rdata_out <= 8'h00;
    end else if (bus_in.rd) begin
      case (bus_in.addr)
        TEMP_RESULT_ADDR:   rdata_out <= temperature_result_r;
        CONV_START_ADDR:    rdata_out <= {5'h00, start_r};
        BATT_RESULT_ADDR:   rdata_out <= battery_result_r;
        SUPPLY_RESULT_ADDR: rdata_out <= supply_result_r;
        IRQ_STATUS_ADDR:    rdata_out <= {5'h00, irq_status_r};
        IRQ_MASK_ADDR:      rdata_out <= {5'h00, irq_mask_r};
        CHANGE_DELTA_ADDR:  rdata_out <= change_delta_config_r;
        BG_PERIOD_ADDR:     rdata_out <= background_period_config_r;
        BATT_THRESH_ADDR:   rdata_out <= battery_low_threshold_r;
        default:            rdata_out <= 8'h00;
      endcase
    end else begin
      rdata_out <= 8'h00;
    end
  end

  assign pll_fault_flag_out = pll_fault_flag_r;
  assign irq_out            = |(irq_status_r & irq_mask_r);

  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (rst_in);

  batt_start_clr_a: assert property (
    ack_take[CH_BATT] && single_r[CH_BATT] && !wr_at(CONV_START_ADDR) |=> !start_r[CH_BATT])
    else $error("battery start bit not cleared on accept");
  temp_start_clr_a: assert property (
    ack_take[CH_TEMP] && single_r[CH_TEMP] && !wr_at(CONV_START_ADDR) |=> !start_r[CH_TEMP])
    else $error("temperature start bit not cleared on accept");
  supply_start_clr_a: assert property (
    ack_take[CH_SUPPLY] && single_r[CH_SUPPLY] && !wr_at(CONV_START_ADDR)
    |=> !start_r[CH_SUPPLY])
    else $error("supply start bit not cleared on accept");
  pll_ack_clr_a: assert property (
    wr_at(CONV_START_ADDR) && bus_in.wdata[PLL_ACK_BIT] && !pll_fault_set_in
    |=> !pll_fault_flag_out)
    else $error("pll fault flag not cleared by acknowledge");
  batt_low_irq_a: assert property (
    done_take[CH_BATT] && conv_in.data[CH_BATT] < battery_low_threshold_r
    |=> irq_status_r[CH_BATT] && battery_result_r == $past(conv_in.data[CH_BATT]))
    else $error("low battery result raised no interrupt");
  supply_hold_a: assert property (
    !irq_event[CH_SUPPLY] && !wr_at(SUPPLY_RESULT_ADDR) |=> $stable(supply_result_r))
    else $error("supply result changed without interrupt");
  batt_hold_a: assert property (
    !irq_event[CH_BATT] && !wr_at(BATT_RESULT_ADDR) |=> $stable(battery_result_r))
    else $error("battery result changed without interrupt");
  temp_hold_a: assert property (
    !irq_event[CH_TEMP] && !wr_at(TEMP_RESULT_ADDR) |=> $stable(temperature_result_r))
    else $error("temperature result changed without interrupt");
  temp_single_req_a: assert property (
    wr_at(CONV_START_ADDR) && bus_in.wdata[CH_TEMP] && g_ch[CH_TEMP].state_r == ST_IDLE
    |-> ##[1:2] conv_req_out[CH_TEMP])
    else $error("temperature request not issued after start");
  period_off_a: assert property (
    period_code[CH_TEMP] == 2'h0 |=> !bg_strobe[CH_TEMP])
    else $error("background strobe while period disabled");
  temp_delta_a: assert property (
    done_take[CH_TEMP] && !single_r[CH_TEMP]
    && change_delta_config_r[TEMP_DELTA_LSB +: 3] == TD_ONE && temp_change_delta <= STEP_ONE
    |=> !irq_status_r[CH_TEMP] || $past(irq_status_r[CH_TEMP]))
    else $error("temperature interrupt below change delta");
  supply_off_a: assert property (
    done_take[CH_SUPPLY] && !single_r[CH_SUPPLY]
    && change_delta_config_r[SUPPLY_DELTA_LSB +: 3] == SD_OFF |-> !irq_event[CH_SUPPLY])
    else $error("supply interrupt with delta disabled");
  reset_zero_a: assert property (@(posedge sys_clk_in) disable iff (1'b0)
    rst_in |=> change_delta_config_r == REG_RESET && background_period_config_r == REG_RESET
    && supply_result_r == REG_RESET && !irq_out)
    else $error("registers not zero after reset");

  single_temp_c: cover property (ack_take[CH_TEMP] && single_r[CH_TEMP]);
  bg_batt_low_c: cover property (irq_event[CH_BATT] && !single_r[CH_BATT]);
  supply_step_c: cover property (irq_event[CH_SUPPLY] && !single_r[CH_SUPPLY]);
  irq_c:         cover property (irq_out);

endmodule // housekeeping_adc_control

// ---- housekeeping_pkg.sv ----
// shared constants, types and helpers for the housekeeping converter control block
package housekeeping_pkg;

  // register byte addresses
  localparam logic [7:0] TEMP_RESULT_ADDR   = 8'hd7;
  localparam logic [7:0] CONV_START_ADDR    = 8'hd8;
  localparam logic [7:0] BATT_RESULT_ADDR   = 8'hdf;
  localparam logic [7:0] SUPPLY_RESULT_ADDR = 8'hef;
  localparam logic [7:0] IRQ_STATUS_ADDR    = 8'hf0;
  localparam logic [7:0] IRQ_MASK_ADDR      = 8'hf1;
  localparam logic [7:0] CHANGE_DELTA_ADDR  = 8'hf3;
  localparam logic [7:0] BG_PERIOD_ADDR     = 8'hf9;
  localparam logic [7:0] BATT_THRESH_ADDR   = 8'hfa;

  localparam logic [7:0] REG_RESET = 8'h00;

  // channel index: also the start bit and the interrupt status bit
  localparam int NUM_CH    = 3;
  localparam int CH_BATT   = 0;
  localparam int CH_TEMP   = 1;
  localparam int CH_SUPPLY = 2;

  // field positions
  localparam int PLL_ACK_BIT       = 7;
  localparam int TEMP_DELTA_LSB    = 3;
  localparam int SUPPLY_DELTA_LSB  = 0;
  localparam int SUPPLY_PERIOD_LSB = 4;
  localparam int BATT_BG_INTERVAL_LSB   = 2;
  localparam int TEMP_PERIOD_LSB   = 0;
  localparam int DELTA_USED_BITS   = 6;

  // timing: one minute at the system clock rate
  localparam int unsigned CLK_HZ            = 20_000_000;
  localparam int unsigned MINUTE_S          = 60;
  localparam int unsigned MINUTE_CYCLES_DEF = CLK_HZ * MINUTE_S;

  // background intervals in minutes
  localparam logic [4:0] MIN_1  = 5'h01;
  localparam logic [4:0] MIN_2  = 5'h02;
  localparam logic [4:0] MIN_4  = 5'h04;
  localparam logic [4:0] MIN_8  = 5'h08;
  localparam logic [4:0] MIN_16 = 5'h10;
  localparam logic [4:0] MIN_NONE = 5'h00;

  // change-delta steps in result LSBs
  localparam logic [7:0] STEP_ZERO         = 8'h00;
  localparam logic [7:0] STEP_ONE          = 8'h01;
  localparam logic [7:0] STEP_TWO          = 8'h02;
  localparam logic [7:0] SUPPLY_LARGE_STEP = 8'h08;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_REQ  = 2'h1,
    ST_BUSY = 2'h2
  } conv_state_t;

  typedef enum logic [2:0] {
    TD_OFF     = 3'h0,
    TD_BELOW_1 = 3'h1,
    TD_ONE     = 3'h3,
    TD_TWO     = 3'h5,
    TD_EVERY   = 3'h7
  } temp_delta_t;

  typedef enum logic [2:0] {
    SD_OFF     = 3'h0,
    SD_BELOW_1 = 3'h1,
    SD_STEP    = 3'h4,
    SD_EVERY   = 3'h7
  } supply_delta_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } reg_bus_t;

  typedef struct packed {
    logic [NUM_CH-1:0]      ack;
    logic [NUM_CH-1:0]      done;
    logic [NUM_CH-1:0][7:0] data;
  } conv_in_t;

  function automatic logic [7:0] abs_diff(input logic [7:0] a, input logic [7:0] b);
    abs_diff = (a >= b) ? (a - b) : (b - a);
  endfunction

endpackage

// ---- bg_interval_timer.sv ----
// background conversion interval timer for one converter channel
`timescale 1ns/1ps
module bg_interval_timer
  import housekeeping_pkg::*;
#(
  parameter logic [4:0] MIN_01 = MIN_8,
  parameter logic [4:0] MIN_10 = MIN_2,
  parameter logic [4:0] MIN_11 = MIN_1
) (
  input  wire logic       sys_clk_in,
  input  wire logic       rst_in,
  input  wire logic       minute_tick_in,
  input  wire logic [1:0] period_code_in,
  output logic            strobe_out
);

  logic [4:0] target;
  logic [4:0] minute_cnt_r;

  always_comb begin
    case (period_code_in)
      2'h1:    target = MIN_01;
      2'h2:    target = MIN_10;
      2'h3:    target = MIN_11;
      default: target = MIN_NONE;
    endcase
  end

  // >= so that shortening the interval mid-count cannot skip a wrap
  always_ff @(posedge sys_clk_in) begin
    if (rst_in || target == MIN_NONE) begin
      minute_cnt_r <= 5'h00;
      strobe_out   <= 1'b0;
    end else if (minute_tick_in) begin
      if (minute_cnt_r + 5'h01 >= target) begin
        minute_cnt_r <= 5'h00;
        strobe_out   <= 1'b1;
      end else begin
        minute_cnt_r <= minute_cnt_r + 5'h01;
        strobe_out   <= 1'b0;
      end
    end else begin
      strobe_out <= 1'b0;
    end
  end

endmodule // bg_interval_timer

// ---- conv_model.sv ----
// converter model: accepts requests, then finishes with a result
`timescale 1ns/1ps
module conv_model
  import housekeeping_pkg::*;
(
  input  wire logic                   sys_clk_in,
  input  wire logic                   rst_in,
  input  wire logic [NUM_CH-1:0]      req_in,
  input  wire logic [NUM_CH-1:0][7:0] value_in,
  input  wire logic                   slow_in,
  output conv_in_t                    conv_out
);
  logic [NUM_CH-1:0][2:0] wait_r;
  logic [NUM_CH-1:0][1:0] run_r;
  logic [NUM_CH-1:0]      busy_r;
  logic [NUM_CH-1:0]      done_r;
  logic [NUM_CH-1:0][7:0] data_r;
  logic [2:0]             dly;

  // slow mode holds off the accept so a pending start bit stays visible
  assign dly = slow_in ? 3'h4 : 3'h0;

  always_comb begin
    for (int c = 0; c < NUM_CH; c++) begin
      conv_out.ack[c]  = req_in[c] && !busy_r[c] && wait_r[c] == dly;
      conv_out.done[c] = done_r[c];
      // data only valid beside done; inverted otherwise so a stale sample shows
      conv_out.data[c] = done_r[c] ? data_r[c] : ~data_r[c];
    end
  end

  always_ff @(posedge sys_clk_in) begin
    for (int c = 0; c < NUM_CH; c++) begin
      done_r[c] <= 1'b0;
      if (rst_in) begin
        wait_r[c] <= 3'h0;
        run_r[c]  <= 2'h0;
        busy_r[c] <= 1'b0;
        data_r[c] <= 8'h00;
      end else if (conv_out.ack[c]) begin
        wait_r[c] <= 3'h0;
        run_r[c]  <= 2'h0;
        busy_r[c] <= 1'b1;
      end else if (busy_r[c]) begin
        run_r[c] <= run_r[c] + 2'h1;
        if (run_r[c] == 2'h2) begin
          busy_r[c] <= 1'b0;
          done_r[c] <= 1'b1;
          data_r[c] <= value_in[c];
        end
      end else if (req_in[c]) begin
        wait_r[c] <= wait_r[c] + 3'h1;
      end
    end
  end
endmodule // conv_model

// ---- test_housekeeping_adc_control.sv ----
// self-checking bench for the housekeeping converter control block
`timescale 1ns/1ps
module test_housekeeping_adc_control
  import housekeeping_pkg::*;
;
  // a short minute keeps background runs to a few dozen cycles
  localparam int unsigned MIN_CYC = 20;
  logic                   sys_clk_in = 1'b0;
  logic                   rst_in = 1'b1;
  reg_bus_t               bus = '0;
  logic [7:0]             rdata;
  conv_in_t               conv;
  logic [NUM_CH-1:0]      req;
  logic                   pll_set = 1'b0;
  logic                   pll_flag;
  logic                   irq;
  logic [NUM_CH-1:0][7:0] value = '0;
  logic                   slow = 1'b1;
  logic [7:0]             d;
  logic [7:0]             exp_res [NUM_CH];
  int                     n_fail = 0;
  int                     cmp_count = 0;
  logic [7:0] addrs [9] = '{TEMP_RESULT_ADDR, CONV_START_ADDR, BATT_RESULT_ADDR,
    SUPPLY_RESULT_ADDR, IRQ_STATUS_ADDR, IRQ_MASK_ADDR, CHANGE_DELTA_ADDR,
    BG_PERIOD_ADDR, BATT_THRESH_ADDR};
  // delta table: channel, code, step above the held result, interrupt expected
  int         dc_ch   [13] = '{1, 1, 1, 1, 1, 1, 1, 2, 2, 2, 2, 2, 2};
  logic [2:0] dc_code [13] = '{0, 1, 3, 3, 5, 5, 7, 0, 1, 1, 4, 4, 7};
  logic [7:0] dc_step [13] = '{5, 1, 1, 2, 2, 3, 0, 9, 1, 0, 8, 9, 0};
  logic       dc_exp  [13] = '{0, 1, 0, 1, 0, 1, 1, 0, 1, 0, 0, 1, 1};

  housekeeping_adc_control #(.MINUTE_CYCLES(MIN_CYC)) i_dut (
    .sys_clk_in        (sys_clk_in),
    .rst_in            (rst_in),
    .bus_in            (bus),
    .rdata_out         (rdata),
    .conv_in           (conv),
    .conv_req_out      (req),
    .pll_fault_set_in  (pll_set),
    .pll_fault_flag_out(pll_flag),
    .irq_out           (irq)
  );

  conv_model i_conv (
    .sys_clk_in(sys_clk_in),
    .rst_in    (rst_in),
    .req_in    (req),
    .value_in  (value),
    .slow_in   (slow),
    .conv_out  (conv)
  );

  always #25 sys_clk_in = ~sys_clk_in;

  task automatic check(input logic [7:0] seen, input logic [7:0] expv);
    cmp_count++;
    if (seen !== expv) begin
      n_fail++;
      $display("wrong value at %0t ns: saw %h, expected %h", $time, seen, expv);
    end
  endtask

  task automatic reg_wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge sys_clk_in);
    bus <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge sys_clk_in);
    bus <= '0;
  endtask

  // read data stand only in the cycle after the strobe, so sample there
  task automatic reg_rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge sys_clk_in);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge sys_clk_in);
    bus <= '0;
    #1 v = rdata;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] expv);
    reg_rd(a, d);
    check(d, expv);
  endtask

  task automatic end_sim;
    $display("comparisons: %0d, mismatches: %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  function automatic logic [7:0] res_addr(input int ch);
    res_addr = ch == CH_BATT ? BATT_RESULT_ADDR :
               ch == CH_TEMP ? TEMP_RESULT_ADDR : SUPPLY_RESULT_ADDR;
  endfunction

  task automatic single(input int ch, input logic [7:0] v);
    value[ch] <= v;
    reg_wr(CONV_START_ADDR, 8'h01 << ch);
    rd_chk(CONV_START_ADDR, 8'h01 << ch);
    for (int i = 0; i < 40 && conv.done[ch] !== 1'b1; i++) begin
      @(posedge sys_clk_in);
    end
    repeat (2) @(posedge sys_clk_in);
    rd_chk(CONV_START_ADDR, 8'h00);
    rd_chk(res_addr(ch), v);
    rd_chk(IRQ_STATUS_ADDR, (8'h01 << ch) | ((8'h01 << ch) - 8'h01));
    exp_res[ch] = v;
  endtask

  task automatic bg(input int ch, input logic [7:0] per, input logic [7:0] v, input logic hit);
    value[ch] <= v;
    reg_wr(IRQ_STATUS_ADDR, 8'h07);
    reg_wr(BG_PERIOD_ADDR, per);
    repeat (70) @(posedge sys_clk_in);
    reg_wr(BG_PERIOD_ADDR, 8'h00);
    repeat (15) @(posedge sys_clk_in);
    if (hit) begin
      exp_res[ch] = v;
    end
    rd_chk(IRQ_STATUS_ADDR, hit ? 8'h01 << ch : 8'h00);
    rd_chk(res_addr(ch), exp_res[ch]);
  endtask

  // two accepts in a row are one interval apart; idle channel keeps strobe-to-accept fixed
  task automatic gap(input int ch, input logic [7:0] per, input logic [7:0] mins);
    int n;
    reg_wr(BG_PERIOD_ADDR, per);
    for (int i = 0; i < 400 && conv.ack[ch] !== 1'b1; i++) begin
      @(posedge sys_clk_in);
    end
    n = 1;
    @(posedge sys_clk_in);
    while (n < 400 && conv.ack[ch] !== 1'b1) begin
      @(posedge sys_clk_in);
      n++;
    end
    reg_wr(BG_PERIOD_ADDR, 8'h00);
    repeat (15) @(posedge sys_clk_in);
    check(8'(n / MIN_CYC), mins);
    check(8'(n % MIN_CYC), 8'h00);
  endtask

  initial begin
    repeat (16) @(posedge sys_clk_in);
    rst_in <= 1'b0;
    repeat (100) @(posedge sys_clk_in);
    check({5'h00, req}, 8'h00);
    check({7'h00, irq}, 8'h00);
    foreach (addrs[i]) rd_chk(addrs[i], REG_RESET);
    reg_wr(8'h00, 8'hff);
    rd_chk(8'h00, 8'h00);
    reg_wr(BATT_THRESH_ADDR, 8'ha5);
    rd_chk(BATT_THRESH_ADDR, 8'ha5);
    reg_wr(CHANGE_DELTA_ADDR, 8'hff);
    rd_chk(CHANGE_DELTA_ADDR, 8'h3f);
    reg_wr(BG_PERIOD_ADDR, 8'hc0);
    rd_chk(BG_PERIOD_ADDR, 8'h00);
    reg_wr(CHANGE_DELTA_ADDR, 8'h00);
    reg_wr(TEMP_RESULT_ADDR, 8'h5a);
    rd_chk(TEMP_RESULT_ADDR, 8'h5a);
    @(posedge sys_clk_in);
    pll_set <= 1'b1;
    @(posedge sys_clk_in);
    pll_set <= 1'b0;
    @(posedge sys_clk_in);
    #1 check({7'h00, pll_flag}, 8'h01);
    reg_wr(CONV_START_ADDR, 8'h80);
    #1 check({7'h00, pll_flag}, 8'h00);
    rd_chk(CONV_START_ADDR, 8'h00);
    single(CH_BATT, 8'hc0);
    single(CH_TEMP, 8'h50);
    single(CH_SUPPLY, 8'h90);
    check({7'h00, irq}, 8'h00);
    reg_wr(IRQ_MASK_ADDR, 8'h02);
    #1 check({7'h00, irq}, 8'h01);
    reg_wr(IRQ_STATUS_ADDR, 8'h05);
    #1 check({7'h00, irq}, 8'h01);
    reg_wr(IRQ_STATUS_ADDR, 8'h02);
    #1 check({7'h00, irq}, 8'h00);
    rd_chk(IRQ_STATUS_ADDR, 8'h00);
    // accept at once from here on so background runs stay short
    slow <= 1'b0;
    reg_wr(BATT_THRESH_ADDR, 8'h40);
    bg(CH_BATT, 8'h0c, 8'h40, 1'b0);
    bg(CH_BATT, 8'h0c, 8'h3f, 1'b1);
    for (int i = 0; i < 13; i++) begin
      reg_wr(CHANGE_DELTA_ADDR, dc_ch[i] == CH_TEMP ? {2'b00, dc_code[i], 3'b000} :
                                                      {5'h00, dc_code[i]});
      bg(dc_ch[i], dc_ch[i] == CH_TEMP ? 8'h03 : 8'h30,
         exp_res[dc_ch[i]] + dc_step[i], dc_exp[i]);
    end
    gap(CH_TEMP, 8'h01, MIN_8);
    gap(CH_TEMP, 8'h02, MIN_2);
    gap(CH_BATT, 8'h04, MIN_16);
    gap(CH_BATT, 8'h08, MIN_4);
    gap(CH_SUPPLY, 8'h10, MIN_8);
    gap(CH_SUPPLY, 8'h20, MIN_2);
    end_sim;
  end

  initial begin
    repeat (20000) @(posedge sys_clk_in);
    n_fail++;
    end_sim;
  end
endmodule // test_housekeeping_adc_control
